// file: encoder_speed_measurement.sv
`timescale 1ns/10ps

// Function
// [RULE1] Per calculation period obtain pulse count and exact time spanning those pulses.
// [RULE2] A pulse counter and an interval timer clocked at system clock over four.
// [RULE3] Both counters are captured together on a Phase A edge.
// [RULE4] A time base fires speed processing every 900 microseconds.
// [RULE5] Each trigger takes differences from previous values, saves new ones, re-arms.
// [RULE6] Only the first Phase A edge after re-arm captures; then capture disarms.
// [RULE7] Speed is scaled so full scale equals 6000 rpm; the code scales one count to about 6000 rpm and clamps at 16'h7FFF.
// [RULE8] The interval timer accumulates under 0x7FFF per calculation period.
// [RULE9] Sized for 1024 pulses per revolution, four edges each.
// [RULE10] Alignment zeroes position, drives d current, settles, zeroes count, drops current.
// [RULE11] Alignment runs once, on the first stop-to-run transition after reset.
// [RULE12] Position counts every edge up or down, cleared by the index pulse.
// [RULE13] Position wraps at plus or minus four times pulses per revolution minus one.
// [RULE14] No capture in a period gives zero pulse difference and no division.
module encoder_speed_measurement
   import enc_speed_pkg::*;
#(
   parameter int PPR = ENC_PPR,
   parameter int PERIOD_CYCLES = CALC_PERIOD_CYC,
   parameter int SETTLE_CYCLES = SETTLE_CYC,
   parameter logic [15:0] ALIGN_CURRENT = 16'h1000
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rstn,
   // Encoder
   input wire enc_pins_t enc,
   // Run/stop switch, high for run
   input wire logic runSwitch,
   // Results
   output speed_result_t result,
   output logic resultValid,
   output logic signed [15:0] rotorPosition,
   output logic signed [15:0] idRequest,
   output logic aligning
);

   localparam int POS_MAX = EDGES_PER_PULSE * PPR - 1;
   localparam logic [31:0] SCALE_K =
      32'((SYS_CLK_MHZ * 1000000 / TIMER_PRESCALE) * 60 / EDGES_PER_PULSE / PPR / MAX_SPEED_RPM);

   typedef enum logic [3:0] {
      A_IDLE = 4'b0001,
      A_DRIVE = 4'b0010,
      A_DONE = 4'b0100,
      A_RUN = 4'b1000
   } align_t;

   // ----------------------------------------------------------------
   // Quadrature decode
   // ----------------------------------------------------------------
   logic prevA, prevB, prevIdx, prevRun;
   logic edgeA, edgeB, countUp, countEvent, indexRise;
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         prevA <= 1'b0;
         prevB <= 1'b0;
         prevIdx <= 1'b0;
         prevRun <= 1'b0;
      end else begin
         prevA <= enc.phaseA;
         prevB <= enc.phaseB;
         prevIdx <= enc.index;
         prevRun <= runSwitch;
      end
   end
   assign edgeA = enc.phaseA ^ prevA;
   assign edgeB = enc.phaseB ^ prevB;
   assign countEvent = edgeA ^ edgeB; // RULE12
   // A leads B in forward rotation: A changed to differ from B, or B changed to equal A.
   assign countUp = edgeA ? (enc.phaseA != enc.phaseB) : (enc.phaseA == enc.phaseB);
   assign indexRise = enc.index & ~prevIdx;

   // ----------------------------------------------------------------
   // Alignment sequence
   // ----------------------------------------------------------------
   align_t state;
   logic [31:0] settleCnt;
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         state <= A_IDLE;
         settleCnt <= '0;
         idRequest <= '0;
         aligning <= 1'b0;
      end else begin
         unique case (state)
            A_IDLE: begin
               if (runSwitch && !prevRun) begin // RULE11
                  state <= A_DRIVE;
                  idRequest <= ALIGN_CURRENT; // RULE10
                  aligning <= 1'b1;
                  settleCnt <= '0;
               end
            end
            A_DRIVE: begin
               settleCnt <= settleCnt + 32'd1;
               if (settleCnt == 32'(SETTLE_CYCLES - 1)) begin
                  state <= A_DONE;
               end
            end
            A_DONE: begin
               idRequest <= '0; // RULE10
               aligning <= 1'b0;
               state <= A_RUN;
            end
            A_RUN: begin
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Rotor position counter
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         rotorPosition <= '0;
      end else if (aligning || indexRise) begin
         // Held at zero while aligning, so the encoder is zero once the rotor settles.
         rotorPosition <= '0; // RULE10 RULE12
      end else if (countEvent) begin
         if (countUp) begin
            rotorPosition <= (rotorPosition == 16'(POS_MAX)) ? '0 : rotorPosition + 16'sd1; // RULE13
         end else begin
            rotorPosition <= (rotorPosition == -16'(POS_MAX)) ? '0 : rotorPosition - 16'sd1; // RULE13
         end
      end
   end

   // ----------------------------------------------------------------
   // Pulse counter, interval timer, time base
   // ----------------------------------------------------------------
   logic [15:0] pulseCount, intervalCount;
   logic [1:0] prescale;
   logic [31:0] baseCnt;
   logic tick;
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         pulseCount <= '0;
      end else if (countEvent) begin
         pulseCount <= pulseCount + 16'd1; // RULE2 RULE9
      end
   end
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         prescale <= '0;
         intervalCount <= '0;
      end else begin
         prescale <= prescale + 2'd1;
         if (prescale == PRESCALE_LAST) begin
            intervalCount <= intervalCount + 16'd1; // RULE2 RULE8
         end
      end
   end
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         baseCnt <= '0;
         tick <= 1'b0;
      end else begin
         tick <= (baseCnt == 32'(PERIOD_CYCLES - 1)); // RULE4
         baseCnt <= (baseCnt == 32'(PERIOD_CYCLES - 1)) ? '0 : baseCnt + 32'd1;
      end
   end

   // ----------------------------------------------------------------
   // One-shot capture
   // ----------------------------------------------------------------
   logic armed, captured;
   logic [15:0] capPulse, capTime, prevPulse, prevTime;
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         armed <= 1'b0;
         captured <= 1'b0;
         capPulse <= '0;
         capTime <= '0;
      end else if (tick) begin
         armed <= 1'b1; // RULE5
         captured <= 1'b0;
      end else if (armed && edgeA) begin
         capPulse <= pulseCount; // RULE3
         capTime <= intervalCount; // RULE3
         armed <= 1'b0; // RULE6
         captured <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Speed processing: differences, then a serial divide
   // ----------------------------------------------------------------
   logic [15:0] dPulse, dTime;
   logic [47:0] num, rem;
   logic [15:0] quot;
   logic [5:0] bitIdx;
   logic dividing;
   logic divDone;
   assign dPulse = captured ? capPulse - prevPulse : 16'h0000; // RULE14
   assign dTime = captured ? capTime - prevTime : 16'h0000;
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         prevPulse <= '0;
         prevTime <= '0;
         result <= '0;
         resultValid <= 1'b0;
         num <= '0;
         rem <= '0;
         quot <= '0;
         bitIdx <= '0;
         dividing <= 1'b0;
         divDone <= 1'b0;
      end else begin
         resultValid <= 1'b0;
         if (tick) begin
            result.pulseDelta <= dPulse; // RULE1 RULE5
            result.timeDelta <= dTime;
            if (captured) begin
               prevPulse <= capPulse; // RULE5
               prevTime <= capTime;
            end
            if (dTime == 16'h0000) begin
               result.speed <= '0; // RULE14
               resultValid <= 1'b1;
            end else begin
               // Division takes 17 cycles, so PERIOD_CYCLES must stay well above that.
               num <= {16'h0000, dPulse} * SCALE_K; // RULE7
               rem <= {32'h0, dTime};
               quot <= '0;
               bitIdx <= 6'd16;
               dividing <= 1'b1;
            end
         end else if (dividing) begin
            if (num >= (rem << (bitIdx - 6'd1))) begin
               num <= num - (rem << (bitIdx - 6'd1));
               quot <= quot | 16'(1 << (bitIdx - 6'd1));
            end
            bitIdx <= bitIdx - 6'd1;
            if (bitIdx == 6'd1) begin
               dividing <= 1'b0;
               divDone <= 1'b1;
            end
         end else if (divDone) begin
            // Speed moves only with its valid pulse, here or in the dTime zero branch, so a zero period keeps its zero.
            // Saturate at full scale: quotients above SPEED_FULL clamp to 16'h7FFF.
            result.speed <= (quot > SPEED_FULL) ? SPEED_FULL : quot; // RULE7
            resultValid <= 1'b1;
            divDone <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   sequence s_armEdge;
      armed && edgeA && !tick;
   endsequence
   a_capture_disarms: assert property (@(posedge sys_clk) disable iff (!rstn)
      s_armEdge |=> !armed && captured && capPulse == $past(pulseCount)) // RULE6
      else $error("capture did not disarm");
   a_tick_rearms: assert property (@(posedge sys_clk) disable iff (!rstn)
      tick |=> armed && !captured) // RULE5
      else $error("tick did not re-arm");
   a_tick_spacing: assert property (@(posedge sys_clk) disable iff (!rstn)
      tick |=> !tick [*8]) // RULE4
      else $error("ticks too close");
   a_no_capture_zero: assert property (@(posedge sys_clk) disable iff (!rstn)
      tick && !captured |=> result.pulseDelta == 16'h0000 && result.speed == 16'h0000
         ##1 result.speed == 16'h0000) // RULE14
      else $error("zero period not zero");
   a_capture_pair: assert property (@(posedge sys_clk) disable iff (!rstn)
      $rose(captured) |-> capTime == $past(intervalCount)) // RULE3
      else $error("timer not captured with count");
   a_pos_range: assert property (@(posedge sys_clk) disable iff (!rstn)
      rotorPosition <= 16'(POS_MAX) && rotorPosition >= -16'(POS_MAX)) // RULE13
      else $error("position out of range");
   a_index_clear: assert property (@(posedge sys_clk) disable iff (!rstn)
      indexRise |=> rotorPosition == 16'sh0000) // RULE12
      else $error("index did not clear");
   a_align_once: assert property (@(posedge sys_clk) disable iff (!rstn)
      state == A_RUN |=> state == A_RUN && !aligning && idRequest == 16'sh0000) // RULE11
      else $error("alignment repeated");
   a_align_current: assert property (@(posedge sys_clk) disable iff (!rstn)
      state == A_DRIVE |-> idRequest == ALIGN_CURRENT ##1 rotorPosition == 16'sh0000) // RULE10
      else $error("alignment current wrong");

endmodule

// file: enc_speed_pkg.sv
package enc_speed_pkg;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int SYS_CLK_MHZ = 125;
   localparam int CALC_PERIOD_US = 900;
   localparam int CALC_PERIOD_CYC = CALC_PERIOD_US * SYS_CLK_MHZ;
   localparam int TIMER_PRESCALE = 4;
   localparam logic [1:0] PRESCALE_LAST = 2'(TIMER_PRESCALE - 1);
   localparam logic [15:0] INTERVAL_LIMIT = 16'h7FFF;
   localparam int ENC_PPR = 1024;
   localparam int EDGES_PER_PULSE = 4;
   localparam int MAX_SPEED_RPM = 6000;
   localparam int SETTLE_US = 500000;
   localparam int SETTLE_CYC = SETTLE_US * SYS_CLK_MHZ;

   // ----------------------------------------------------------------
   // Speed result: clamps at 16'h7FFF; SCALE_K makes one count about MAX_SPEED_RPM.
   // ----------------------------------------------------------------
   localparam logic [15:0] SPEED_FULL = 16'h7FFF;

   typedef struct packed {
      logic [15:0] pulseDelta;
      logic [15:0] timeDelta;
      logic [15:0] speed;
   } speed_result_t;

   typedef struct packed {
      logic phaseA;
      logic phaseB;
      logic index;
   } enc_pins_t;

endpackage

// file: enc_model.sv
`timescale 1ns/10ps

// ----------------------------------------------------------------
// Quadrature encoder on the motor shaft
// ----------------------------------------------------------------
module enc_model
   import enc_speed_pkg::*;
(
   // Clock
   input wire logic sys_clk,
   // Encoder levels
   output enc_pins_t enc
);
   logic [1:0] phase = 2'h0;

   initial enc = '0;

   // One edge per call; phase A leads phase B when turning forward.
   task automatic step(input bit fwd);
      @(posedge sys_clk);
      phase = fwd ? phase + 2'h1 : phase - 2'h1;
      enc.phaseA <= phase[1] ^ phase[0];
      enc.phaseB <= phase[1];
   endtask

   // The index is a short high pulse; the phases keep their levels.
   task automatic mark_index();
      @(posedge sys_clk);
      enc.index <= 1'b1;
      @(posedge sys_clk);
      enc.index <= 1'b0;
   endtask
endmodule

// file: encoder_speed_measurement_tb.sv
`timescale 1ns/10ps

module encoder_speed_measurement_tb
   import enc_speed_pkg::*;
   ;
   localparam int SETTLE = 20;
   localparam logic [15:0] ALIGN_I = 16'h1000;
   localparam int GAP = 10;
   // A short calculation period keeps the run brief; it must stay a multiple of 2 * GAP.
   localparam int PERIOD = 2000;
   localparam int SCALE = (SYS_CLK_MHZ * 1000000 / TIMER_PRESCALE * 60)
      / (EDGES_PER_PULSE * ENC_PPR * MAX_SPEED_RPM);

   logic sys_clk = 1'b0;
   logic rstn = 1'b0;
   logic runSwitch = 1'b0;
   enc_pins_t enc;
   speed_result_t result;
   logic resultValid;
   logic signed [15:0] rotorPosition;
   logic signed [15:0] idRequest;
   logic aligning;
   int cyc = 0;
   int vt = 0;
   int n_mismatch = 0;
   int comparisons = 0;

   always #4 sys_clk = ~sys_clk;

   always @(posedge sys_clk) cyc <= cyc + 1;

   encoder_speed_measurement #(
      .PPR(ENC_PPR), .PERIOD_CYCLES(PERIOD), .SETTLE_CYCLES(SETTLE), .ALIGN_CURRENT(ALIGN_I)
   )
   u_dut (
      .sys_clk(sys_clk), .rstn(rstn), .enc(enc), .runSwitch(runSwitch), .result(result),
      .resultValid(resultValid), .rotorPosition(rotorPosition), .idRequest(idRequest),
      .aligning(aligning)
   );

   enc_model u_enc (.sys_clk(sys_clk), .enc(enc));

   // ----------------------------------------------------------------
   // Checking and closing
   // ----------------------------------------------------------------
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[ERR] %0t ns: saw %h, expected %h", $time, seen, exp);
      end
   endtask

   task automatic stop_test();
      if (n_mismatch == 0 && comparisons > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // Reads happen just after the edge so the design's updates have landed.
   task automatic tick_edge();
      @(posedge sys_clk);
      #1;
   endtask

   task automatic wait_valid(input int lim);
      int n = 0;
      tick_edge();
      while (resultValid !== 1'b1 && n < lim) begin
         tick_edge();
         n++;
      end
      chk(16'(n < lim), 16'h0001);
   endtask

   task automatic move(input int n, input bit fwd, input logic [15:0] exp);
      repeat (n) u_enc.step(fwd);
      repeat (3) tick_edge();
      chk(rotorPosition, exp);
   endtask

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic s_align();
      int n = 0;
      tick_edge();
      chk(idRequest, 16'h0000);
      chk(16'(aligning), 16'h0000);
      @(posedge sys_clk);
      runSwitch <= 1'b1;
      repeat (2) tick_edge();
      chk(16'(aligning), 16'h0001);
      chk(idRequest, ALIGN_I);
      chk(rotorPosition, 16'h0000);
      while (aligning === 1'b1 && n < 60) begin
         tick_edge();
         n++;
      end
      chk(16'(n), 16'(SETTLE));
      chk(idRequest, 16'h0000);
      chk(rotorPosition, 16'h0000);
      @(posedge sys_clk);
      runSwitch <= 1'b0;
      repeat (3) @(posedge sys_clk);
      runSwitch <= 1'b1;
      repeat (10) begin
         tick_edge();
         chk(16'(aligning), 16'h0000);
      end
      chk(idRequest, 16'h0000);
   endtask

   // No encoder edge in the first period, so nothing was captured.
   task automatic s_idle();
      wait_valid(PERIOD + 40);
      vt = cyc;
      chk(result.pulseDelta, 16'h0000);
      chk(result.timeDelta, 16'h0000);
      tick_edge();
      chk(result.speed, 16'h0000);
      chk(16'(resultValid), 16'h0000);
   endtask

   // Steady edges every GAP cycles; only the first A edge after each re-arm may count.
   task automatic s_speed();
      logic [15:0] pd;
      logic [15:0] td;
      pd = 16'(PERIOD / GAP);
      td = 16'(PERIOD / TIMER_PRESCALE);
      fork
         repeat (2 * PERIOD / GAP + 10) begin
            repeat (GAP - 1) @(posedge sys_clk);
            u_enc.step(1'b1);
         end
         begin
            while (cyc < vt + 2 * PERIOD - 8) tick_edge();
            wait_valid(40);
            chk(16'(cyc - vt - 2 * PERIOD), 16'h0011);
            chk(result.pulseDelta, pd);
            chk(result.timeDelta, td);
            chk(16'(result.timeDelta < INTERVAL_LIMIT), 16'h0001);
            chk(result.speed, 16'(32'(pd) * SCALE / 32'(td)));
            tick_edge();
            chk(16'(resultValid), 16'h0000);
         end
      join
   endtask

   // The shaft stops: the next period still holds a capture, the one after has none.
   task automatic s_stop();
      wait_valid(PERIOD + 40);
      chk(result.pulseDelta, 16'(PERIOD / GAP));
      wait_valid(PERIOD + 40);
      chk(result.pulseDelta, 16'h0000);
      chk(result.timeDelta, 16'h0000);
      chk(result.speed, 16'h0000);
      repeat (20) tick_edge();
      chk(result.speed, 16'h0000);
   endtask

   task automatic s_position();
      u_enc.mark_index();
      move(5, 1'b1, 16'h0005);
      move(8, 1'b0, 16'hFFFD);
      u_enc.mark_index();
      move(0, 1'b1, 16'h0000);
      move(4 * ENC_PPR - 1, 1'b1, 16'(4 * ENC_PPR - 1));
      move(1, 1'b1, 16'h0000);
      move(4 * ENC_PPR - 1, 1'b0, 16'(1 - 4 * ENC_PPR));
      move(1, 1'b0, 16'h0000);
   endtask

   initial begin
      repeat (10) @(posedge sys_clk);
      rstn <= 1'b1;
      s_align();
      s_idle();
      s_speed();
      s_stop();
      s_position();
      stop_test();
   end

   initial begin
      repeat (6 * PERIOD + 12000) @(posedge sys_clk);
      n_mismatch++;
      stop_test();
   end
endmodule
